// [common/ddcp_params.svh]
// Constants for the dual mode serial memory port
// What this block does
// - Program cycle lasts at most 10 ms after the ending STOP.
// - While programming, SDA released and own address not acknowledged.
// - Power-up enters transmit-only mode, one bit per transmit clock.
// - Falling SCL edge switches to bidirectional mode until power-down.
// - Transmit-only: 8 bits MSB first, then a released ninth slot.
// - Transmit-only walks whole array, wrapping 7FH to 00H.
// - Nine initialization pulses precede data; ninth slot released.
// - SDA low through first eight init clocks starts at 7FH.
// - Bidirectional mode ignores transmit clock except its level.
// - SDA change while SCL high means START or STOP.
// - Bus ignored until a START is seen.
// - Every operation ends with STOP, which the device detects.
// - Slave address 1010xxx, last bit 1 read, 0 write.
// - Acknowledge matching address, and every written byte.
// - Receiver pulls SDA low in the ninth clock.
// - Read: send 8 bits, sample ack, continue or wait for STOP.
// - Byte write: address, word address, data, STOP starts programming.
// - SDA only pulled low or released.
// - Transmit clock low in bidirectional mode write-protects array.
// - Page write of 16 bytes wraps in the low address bits.
// - Address counter is last address plus one, wraps 127 to 0; after a write it wraps inside the page.
`ifndef DDCP_PARAMS_SVH
`define DDCP_PARAMS_SVH
`define DDCP_CLK_NS         40
`define DDCP_PROG_MS        10
`define DDCP_TPU_MS         1
`define DDCP_PROG_CYC       ((`DDCP_PROG_MS * 1000000) / `DDCP_CLK_NS)
`define DDCP_DEV_CODE       4'h0a
`define DDCP_ADDR_TOP       7'h7f
`define DDCP_ADDR_ZERO      7'h00
`define DDCP_INIT_PULSES    4'h9
`define DDCP_PAGE_MASK      7'h0f
`endif

// [common/ddcp_pkg.sv]
// Types for the dual mode serial memory port
package ddcp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RXB  = 3'b001,
    ST_ACK  = 3'b010,
    ST_TXB  = 3'b011,
    ST_RACK = 3'b100,
    ST_WAIT = 3'b101
  } ddcp_bus_t;
  typedef enum logic [1:0] {
    PH_DEV  = 2'b00,
    PH_WORD = 2'b01,
    PH_DATA = 2'b10,
    PH_READ = 2'b11
  } ddcp_phase_t;
endpackage

// [hdl/ddcp_edge_sync.sv]
// Two-flop pin synchroniser with edge pulses
`timescale 1ns/1ps
module ddcp_edge_sync (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~last_q;
  assign fall  = ~sync_q & last_q;
endmodule

// [hdl/ddcp_port.sv]
// Dual mode serial memory port: transmit-only stream and I2C slave
`timescale 1ns/1ps
`include "ddcp_params.svh"
module ddcp_port #(
  parameter int PROG_CYCLES = `DDCP_PROG_CYC
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  input  wire logic transmit_only_clock,
  output logic      biMode,
  output logic      programBusy
);
  import ddcp_pkg::*;

  // Program counter needs at least one cycle to finish
  if (PROG_CYCLES < 1) begin : gProgCheck
    $error("PROG_CYCLES must be at least 1");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sclLvl, sclRise, sclFall;
  logic sdaLvl, sdaRise, sdaFall;
  logic txcLvl, txcRise;

  ddcp_edge_sync uScl (.clock(clock), .rstn(rstn), .pinIn(sclIn),
    .level(sclLvl), .rise(sclRise), .fall(sclFall));
  ddcp_edge_sync uSda (.clock(clock), .rstn(rstn), .pinIn(sdaIn),
    .level(sdaLvl), .rise(sdaRise), .fall(sdaFall));
  ddcp_edge_sync uTxc (.clock(clock), .rstn(rstn),
    .pinIn(transmit_only_clock),
    .level(txcLvl), .rise(txcRise), .fall());

  // ----------------------------------------------------------------
  // Storage and shared state
  // ----------------------------------------------------------------
  logic [7:0] mem [0:127];
  logic       bi_q;
  logic [6:0] addr_q;
  logic [6:0] addr_d;
  logic [31:0] progCnt_q;
  logic       busy_q;

  // ----------------------------------------------------------------
  // Transmit-only stream
  // ----------------------------------------------------------------
  logic       initDone_q;
  logic [3:0] initCnt_q;
  logic       initLow_q;
  logic [3:0] slot_q;
  logic [7:0] txShift_q;
  logic       txDrive_q;

  // SDA is sampled while the host may hold it, at the rising edge of each of the first eight pulses
  wire initFirstEight = (initCnt_q < 4'h8);
  wire initLast       = (initCnt_q == 4'h8);
  wire [6:0] initStart = initLow_q ? `DDCP_ADDR_TOP : `DDCP_ADDR_ZERO;
  wire [3:0] slotNext  = (slot_q == 4'h8) ? 4'h0 : slot_q + 4'h1;
  wire       streamTick = !bi_q && txcRise;

  // First word after init comes from the strapped start address
  logic       firstWord_q;
  wire [6:0]  initDoneAddr = firstWord_q ? initStart : addr_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bi_q <= 1'b0;
    end else if (sclFall) begin
      bi_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      initDone_q <= 1'b0;
      initCnt_q  <= 4'h0;
      initLow_q  <= 1'b1;
      slot_q     <= 4'h0;
      txShift_q  <= 8'h00;
      txDrive_q  <= 1'b0;
    end else if (streamTick && !initDone_q) begin
      initCnt_q <= initCnt_q + 4'h1;
      if (initFirstEight && sdaLvl) begin
        initLow_q <= 1'b0;
      end
      txDrive_q <= 1'b0;
      if (initLast) begin
        initDone_q <= 1'b1;
        slot_q     <= 4'h8;
      end
    end else if (streamTick) begin
      slot_q <= slotNext;
      if (slot_q == 4'h8) begin
        txShift_q <= mem[initDoneAddr];
        txDrive_q <= ~mem[initDoneAddr][7];
      end else if (slot_q == 4'h7) begin
        txDrive_q <= 1'b0;
      end else begin
        txShift_q <= {txShift_q[6:0], 1'b0};
        txDrive_q <= ~txShift_q[6];
      end
    end else if (bi_q) begin
      txDrive_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      firstWord_q <= 1'b1;
    end else if (streamTick && initDone_q && slot_q == 4'h8) begin
      firstWord_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // I2C slave
  // ----------------------------------------------------------------
  ddcp_bus_t   st_q;
  ddcp_phase_t ph_q;
  logic [2:0]  bit_q;
  logic [7:0]  rx_q;
  logic [7:0]  tx_q;
  logic        i2cDrive_q;
  logic [3:0]  pageCnt_q;
  logic [7:0]  page_q [0:15];
  logic [6:0]  pageBase_q;
  logic        pend_q;
  logic        wp_q;
  logic        pageFull_q;

  wire startSeen = bi_q && sclLvl && sdaFall;
  wire stopSeen  = bi_q && sclLvl && sdaRise;
  wire [7:0] rxNext  = {rx_q[6:0], sdaLvl};
  // upper nibble match, low bit direction
  wire devMatch = (rxNext[7:4] == `DDCP_DEV_CODE);
  wire dirRead  = rxNext[0];
  // only the level of the transmit clock matters
  wire writeOk  = txcLvl;
  wire [6:0] addrInc = addr_q + 7'h01;
  // low bits wrap inside the page
  wire [6:0] pageSlot = (pageBase_q & ~`DDCP_PAGE_MASK)
                      | ((pageBase_q + {3'h0, pageCnt_q}) & `DDCP_PAGE_MASK);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q       <= ST_IDLE;
      ph_q       <= PH_DEV;
      bit_q      <= 3'h0;
      rx_q       <= 8'h00;
      tx_q       <= 8'h00;
      i2cDrive_q <= 1'b0;
      pageCnt_q  <= 4'h0;
      pageBase_q <= 7'h00;
      pend_q     <= 1'b0;
      wp_q       <= 1'b0;
      pageFull_q <= 1'b0;
    end else if (busy_q || !bi_q) begin
      st_q       <= ST_IDLE;
      i2cDrive_q <= 1'b0;
      pend_q     <= 1'b0;
    end else if (stopSeen) begin
      st_q       <= ST_IDLE;
      i2cDrive_q <= 1'b0;
      pend_q     <= 1'b0;
    end else if (startSeen) begin
      st_q       <= ST_RXB;
      ph_q       <= PH_DEV;
      bit_q      <= 3'h0;
      i2cDrive_q <= 1'b0;
      pend_q     <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          i2cDrive_q <= 1'b0;
        end
        ST_RXB: if (sclRise) begin
          rx_q  <= rxNext;
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_q <= ST_ACK;
            if (ph_q == PH_DEV && !devMatch) begin
              st_q <= ST_WAIT;
            end else if (ph_q == PH_DEV) begin
              ph_q <= dirRead ? PH_READ : PH_WORD;
            end else if (ph_q == PH_WORD) begin
              pageBase_q <= rxNext[6:0];
              pageCnt_q  <= 4'h0;
              pageFull_q <= 1'b0;
              ph_q       <= PH_DATA;
            end else begin
              page_q[pageCnt_q] <= rxNext;
              pageCnt_q <= pageCnt_q + 4'h1;
              if (pageCnt_q == 4'hf) begin
                pageFull_q <= 1'b1;
              end
              pend_q    <= 1'b1;
              wp_q      <= ~writeOk;
            end
          end
        end
        ST_ACK: begin
          // pull SDA low through ninth clock
          if (sclFall && !i2cDrive_q) begin
            i2cDrive_q <= 1'b1;
          end else if (sclFall && i2cDrive_q) begin
            i2cDrive_q <= 1'b0;
            bit_q      <= 3'h0;
            if (ph_q == PH_READ) begin
              st_q       <= ST_TXB;
              tx_q       <= mem[addr_q];
              i2cDrive_q <= ~mem[addr_q][7];
            end else begin
              st_q <= ST_RXB;
            end
          end
        end
        ST_TXB: if (sclFall) begin
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            i2cDrive_q <= 1'b0;
            st_q       <= ST_RACK;
          end else begin
            tx_q       <= {tx_q[6:0], 1'b0};
            i2cDrive_q <= ~tx_q[6];
          end
        end
        ST_RACK: begin
          // continue on ack, else wait for STOP
          if (sclRise && sdaLvl) begin
            st_q <= ST_WAIT;
          end else if (sclFall) begin
            // Next byte starts at the fall ending the ack clock
            st_q       <= ST_TXB;
            bit_q      <= 3'h0;
            tx_q       <= mem[addr_q];
            i2cDrive_q <= ~mem[addr_q][7];
          end
        end
        ST_WAIT: begin
          i2cDrive_q <= 1'b0;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // address counter: last accessed plus one
  always_comb begin
    addr_d = addr_q;
    if (streamTick && initDone_q && slot_q == 4'h8) begin
      addr_d = initDoneAddr + 7'h01;
    end else if (bi_q && st_q == ST_RXB && sclRise && bit_q == 3'h7
                 && ph_q == PH_WORD) begin
      addr_d = rxNext[6:0];
    end else if (bi_q && st_q == ST_RACK && sclRise) begin
      addr_d = addrInc;
    end else if (stopSeen && pend_q) begin
      addr_d = pageSlot;
    end
  end

  // STOP after data starts timed programming
  wire progStart = stopSeen && pend_q && !wp_q && !busy_q;
  wire progDone  = busy_q && (progCnt_q == PROG_CYCLES - 1);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      addr_q    <= 7'h00;
      busy_q    <= 1'b0;
      progCnt_q <= 32'h0000_0000;
    end else begin
      addr_q <= addr_d;
      if (progStart) begin
        busy_q    <= 1'b1;
        progCnt_q <= 32'h0000_0000;
      end else if (progDone) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        progCnt_q <= progCnt_q + 32'h0000_0001;
      end
    end
  end

  // Page buffer commits at the STOP; memory has no reset on purpose
  always_ff @(posedge clock) begin
    if (progStart) begin
      for (int i = 0; i < 16; i++) begin
        if (i[3:0] < pageCnt_q || pageFull_q) begin
          mem[(pageBase_q & ~`DDCP_PAGE_MASK)
              | ((pageBase_q + 7'(i)) & `DDCP_PAGE_MASK)] <= page_q[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Open-drain SDA
  // ----------------------------------------------------------------
  // only pull low or release
  assign sdaOut      = 1'b0;
  assign sdaOe       = bi_q ? i2cDrive_q : txDrive_q;
  assign biMode      = bi_q;
  assign programBusy = busy_q;
endmodule

// [tb/ddcp_port_asserts.sv]
// Pin level checks for the dual mode memory port
`timescale 1ns/1ps
module ddcp_port_asserts #(
  parameter int PROG_CYCLES = 400
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  input  wire logic sdaOut,
  input  wire logic sdaOe,
  input  wire logic transmit_only_clock,
  input  wire logic biMode,
  input  wire logic programBusy
);
  logic        txcPrev_q;
  logic [3:0]  initCnt_q;
  logic [3:0]  pos_q;
  logic [31:0] busyCnt_q;
  logic        txcRise;
  logic        initDone;
  assign txcRise  = transmit_only_clock & ~txcPrev_q;
  assign initDone = (initCnt_q == 4'ha);
  // Raw pin edges lead the design's view by its synchroniser delay
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txcPrev_q <= 1'b0;
      initCnt_q <= 4'h0;
      pos_q     <= 4'h0;
      busyCnt_q <= 32'h0000_0000;
    end else begin
      txcPrev_q <= transmit_only_clock;
      busyCnt_q <= programBusy ? busyCnt_q + 32'h0000_0001
                               : 32'h0000_0000;
      if (txcRise && !initDone) begin
        initCnt_q <= initCnt_q + 4'h1;
      end
      if (txcRise && initDone) begin
        pos_q <= (pos_q == 4'h8) ? 4'h0 : pos_q + 4'h1;
      end
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_sda_open_drain: assert property (sdaOe |-> !sdaOut)
    else $error("SDA driven high");
  a_mode_sticky: assert property (biMode |=> biMode)
    else $error("left bidirectional mode");
  a_mode_entry: assert property (!biMode && $fell(sclIn)
    |-> ##[1:8] biMode)
    else $error("SCL fall kept transmit mode");
  a_busy_quiet: assert property (programBusy |-> !sdaOe)
    else $error("SDA pulled while programming");
  a_busy_bound: assert property (programBusy
    |-> busyCnt_q < 32'(PROG_CYCLES))
    else $error("program cycle too long");
  a_busy_after_stop: assert property ($rose(programBusy)
    |-> biMode && sclIn)
    else $error("programming without STOP");
  a_init_quiet: assert property (!biMode && !initDone |-> !sdaOe)
    else $error("SDA pulled during init");
  a_ninth_quiet: assert property (!biMode && txcRise && initDone
    && pos_q == 4'h7 |-> ##6 !sdaOe)
    else $error("ninth slot not released");
  cover property ($rose(biMode));
  cover property ($rose(programBusy));
  cover property (txcRise && initDone && pos_q == 4'h7);
endmodule

// [tb/ddcp_host.sv]
// Display host model: I2C master and transmit clock source
`timescale 1ns/1ps
module ddcp_host (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sdaLow,
  output logic      txc
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
    txc = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // data moves only while SCL low
  task automatic bitIo(input logic b, output logic r);
    tick(2);
    sdaLow = ~b;
    tick(6);
    scl = 1'b1;
    tick(6);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    sdaLow = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(6);
    sdaLow = 1'b1;
    tick(6);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sdaLow = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(6);
    sdaLow = 1'b0;
    tick(6);
  endtask
  task automatic putByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitIo(d[i], r);
    bitIo(1'b1, r);
    ack = ~r;
  endtask
  task automatic getByte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, r);
      d[i] = r;
    end
    bitIo(~more, r);
  endtask
  // one 160 ns pulse in a 320 ns slot with SCL held high
  task automatic pulse(input logic hold, output logic r);
    sdaLow = hold;
    tick(1);
    txc = 1'b1;
    tick(4);
    txc = 1'b0;
    tick(3);
    r = sda;
  endtask
endmodule

// [tb/ddcp_port_bench.sv]
// Self-checking bench for the dual mode memory port
`timescale 1ns/1ps
module ddcp_port_bench;
  localparam int PROG = 400;
  // Power settle shortened from the host's real wait
  localparam int PWR = 100;
  logic       clock;
  logic       rstn;
  logic       scl;
  logic       hostLow;
  logic       txc;
  logic       sdaOut;
  logic       sdaOe;
  logic       biMode;
  logic       programBusy;
  wire        sda;
  int         miscompares;
  int         num_checks;
  logic [15:0] lfsr;
  logic [7:0] dA;
  logic [7:0] dB;
  logic [7:0] dC;
  logic [7:0] d;
  logic       ack;
  // Pull-up on the wired-AND data line
  assign sda = ~((sdaOe & ~sdaOut) | hostLow);
  ddcp_port #(.PROG_CYCLES(PROG)) u_ddcp_port (.clock(clock), .rstn(rstn),
    .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .transmit_only_clock(txc), .biMode(biMode), .programBusy(programBusy));
  ddcp_host u_ddcp_host (.clock(clock), .sda(sda), .scl(scl),
    .sdaLow(hostLow), .txc(txc));
  always #20 clock = ~clock;
  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic powerUp();
    rstn = 1'b0;
    u_ddcp_host.txc = 1'b0;
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    repeat (PWR) @(negedge clock);
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    while (programBusy !== 1'b0 && n < 4 * PROG) begin
      @(negedge clock);
      n++;
    end
    check({7'h00, programBusy}, 8'h00, "busy stuck");
    if (n >= 4 * PROG)
      conclude();
  endtask
  task automatic devSel(input logic rd);
    lfsr = nextRand(lfsr);
    u_ddcp_host.start();
    u_ddcp_host.putByte({4'ha, lfsr[2:0], rd}, ack);
    check({7'h00, ack}, 8'h01, "address ack");
  endtask
  task automatic writeByte(input logic [7:0] a, input logic [7:0] v);
    devSel(1'b0);
    u_ddcp_host.putByte(a, ack);
    check({7'h00, ack}, 8'h01, "word ack");
    u_ddcp_host.putByte(v, ack);
    check({7'h00, ack}, 8'h01, "data ack");
    u_ddcp_host.stop();
  endtask
  task automatic readAt(input logic [7:0] a, input logic more);
    devSel(1'b0);
    u_ddcp_host.putByte(a, ack);
    devSel(1'b1);
    u_ddcp_host.getByte(more, d);
  endtask
  task automatic noAck(input logic [7:0] sel);
    u_ddcp_host.start();
    u_ddcp_host.putByte(sel, ack);
    check({7'h00, ack}, 8'h00, "unexpected ack");
    u_ddcp_host.stop();
  endtask
  task automatic txInit(input logic low);
    logic r;
    for (int i = 0; i < 9; i++)
      u_ddcp_host.pulse(low && i < 8, r);
    check({7'h00, r}, 8'h01, "init ninth");
  endtask
  task automatic txByte(input logic [7:0] e);
    logic [7:0] v;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      u_ddcp_host.pulse(1'b0, r);
      v[i] = r;
    end
    check(v, e, "stream byte");
    u_ddcp_host.pulse(1'b0, r);
    check({7'h00, r}, 8'h01, "ninth slot");
  endtask
  initial begin
    clock = 1'b0;
    miscompares = 0;
    num_checks = 0;
    lfsr = 16'h9540;
    powerUp();
    check({7'h00, biMode}, 8'h00, "power-up mode");
    u_ddcp_host.start();
    u_ddcp_host.stop();
    check({7'h00, biMode}, 8'h01, "mode switch");
    u_ddcp_host.txc = 1'b1;
    lfsr = nextRand(lfsr);
    dA = lfsr[7:0];
    lfsr = nextRand(lfsr);
    dB = lfsr[7:0];
    writeByte(8'h7f, dA);
    noAck(8'ha0);
    waitIdle();
    writeByte(8'h00, dB);
    waitIdle();
    $display("byte writes and busy polling done");
    readAt(8'h7f, 1'b1);
    check(d, dA, "read top");
    u_ddcp_host.getByte(1'b0, d);
    check(d, dB, "read wrap");
    u_ddcp_host.stop();
    u_ddcp_host.txc = 1'b0;
    writeByte(8'h00, ~dB);
    waitIdle();
    u_ddcp_host.txc = 1'b1;
    readAt(8'h00, 1'b0);
    u_ddcp_host.stop();
    check(d, dB, "protected byte");
    noAck(8'h91);
    // Three bytes from 1E: the third wraps to 10 inside the page
    lfsr = nextRand(lfsr);
    dC = lfsr[7:0];
    devSel(1'b0);
    u_ddcp_host.putByte(8'h1e, ack);
    u_ddcp_host.putByte(dA, ack);
    check({7'h00, ack}, 8'h01, "page ack");
    u_ddcp_host.putByte(dB, ack);
    u_ddcp_host.putByte(dC, ack);
    check({7'h00, ack}, 8'h01, "page wrap ack");
    u_ddcp_host.stop();
    waitIdle();
    readAt(8'h1e, 1'b1);
    check(d, dA, "page first");
    u_ddcp_host.getByte(1'b0, d);
    u_ddcp_host.stop();
    check(d, dB, "page second");
    readAt(8'h10, 1'b0);
    u_ddcp_host.stop();
    check(d, dC, "page wrap");
    $display("page write done");
    $display("reads, protection and foreign address done");
    powerUp();
    txInit(1'b1);
    txByte(dA);
    txByte(dB);
    check({7'h00, biMode}, 8'h00, "stream mode");
    powerUp();
    txInit(1'b0);
    txByte(dB);
    $display("transmit-only streams done");
    conclude();
  end
endmodule
bind ddcp_port ddcp_port_asserts #(.PROG_CYCLES(PROG_CYCLES))
  u_ddcp_port_asserts (
  .clock(clock), .rstn(rstn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .transmit_only_clock(transmit_only_clock), .biMode(biMode),
  .programBusy(programBusy));
